// ==== rss_pkg.sv ====
`default_nettype none

package rss_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned POR_MIN_NS = 100;
  // least time, rounded up
  localparam int unsigned POR_MIN_CYC =
    (POR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] STRETCH_LOAD =
    CNT_W'(POR_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_LEVEL = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_SWRST = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_WDT_CTRL = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_WDT_TIMEOUT = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_WDT_KICK = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h018;

  // control fields
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned CTRL_ALV_EN = 0;
  localparam int unsigned CTRL_DLV_EN = 1;
  localparam int unsigned CTRL_AHV_EN = 2;
  localparam int unsigned CTRL_ALV_RST = 3;
  localparam int unsigned CTRL_DLV_RST = 4;
  localparam int unsigned CTRL_AREG_EN = 5;
  localparam int unsigned CTRL_SW_DIS = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h20;

  // trip level fields
  localparam int unsigned LVL_W = 4;
  localparam int unsigned LVL_ALV_LSB = 0;
  localparam int unsigned LVL_DLV_LSB = 4;
  localparam logic [LVL_W-1:0] LVL_RST = 4'h0;
  localparam int unsigned LV_MIN_MV = 1700;
  localparam int unsigned LV_STEP_MV = 250;
  localparam int unsigned AHV_TRIP_MV = 5750;

  localparam int unsigned SWRST_BIT = 0;
  localparam int unsigned WDT_EN_BIT = 0;

  // status fields
  localparam int unsigned ST_W = 9;
  localparam int unsigned ST_PREC = 0;
  localparam int unsigned ST_EXT = 1;
  localparam int unsigned ST_SW = 2;
  localparam int unsigned ST_WDT = 3;
  localparam int unsigned ST_ALV_RST = 4;
  localparam int unsigned ST_DLV_RST = 5;
  localparam int unsigned ST_ALV_IRQ = 6;
  localparam int unsigned ST_DLV_IRQ = 7;
  localparam int unsigned ST_AHV_IRQ = 8;
  localparam logic [ST_W-1:0] ST_RST = 9'h000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic prec_dig;
    logic prec_ana;
    logic alv;
    logic dlv;
    logic ahv;
  } rss_mon_type;

  typedef enum logic [2:0] {
    SEQ_HOLD = 3'b001,
    SEQ_STRETCH = 3'b010,
    SEQ_RUN = 3'b100
  } rss_seq_type;

endpackage

`default_nettype wire

// ==== rss_supervisor.sv ====
// Summary of operation
// - precise supply monitor trip gives the same reset as power-on reset
// - software has no control bit that turns off the digital precise monitor
// - analog precise monitor is off whenever the analog regulator is off
// - precise monitor off in sleep and hibernate, on only during buzz windows
// - analog high supply monitor uses one fixed threshold, nothing selectable
// - analog and digital low monitors each take a 4-bit, 16-step trip level
// - each low monitor can be set to reset the device instead of interrupting
// - low and high supply monitors stay off until power-on reset is over
// - monitors buzz in sleep; a trip asks for wakeup, interrupt shows after
// - device stays in reset while the external reset input is held low
// - external reset gives the same reset as power-on reset
// - external reset keeps working in sleep and hibernate
// - writing one to the software reset bit, by any master, requests reset
// - software reset gives the same reset as power-on reset
// - a separate disable bit stops the software reset bit from acting
// - watchdog not cleared within its timeout produces a watchdog reset
// - power-on reset leaves the watchdog off until software enables it
// - watchdog enable ignores clears once set; only power-on reset clears it
// - status register records reset and monitor sources, cleared by power-on
// - power-on reset pulse lasts at least 100 ns, longer while sources stay
`timescale 1ns/1ps
`default_nettype none

module rss_supervisor #(
  parameter logic [31:0] WDT_TIMEOUT_DEF = 32'h000F_FFFF,
  parameter int unsigned BUZZ_PERIOD = 1000,
  parameter int unsigned BUZZ_LEN = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rss_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rss_pkg::rss_mon_type trip,
  input wire logic external_reset_pin_n,
  input wire logic gpio_reset_n,
  input wire logic gpio_reset_sel,
  input wire logic sleep_mode,
  input wire logic hibernate_mode,
  output rss_pkg::rss_mon_type mon_en,
  output logic [rss_pkg::LVL_W-1:0] analog_low_level,
  output logic [rss_pkg::LVL_W-1:0] digital_low_level,
  output logic buzz,
  output logic device_rst,
  output logic supervisor_irq,
  output logic wakeup_req
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (BUZZ_LEN == 0 || BUZZ_LEN >= BUZZ_PERIOD) begin : g_bad_buzz
    $error("buzz window must be nonzero and shorter than its period");
  end
  if (BUZZ_PERIOD > 32'h00FF_FFFF) begin : g_bad_period
    $error("buzz period too large for its counter");
  end

  // address match for one register
  function automatic logic reg_is(
    input logic [rss_pkg::ADDR_W-1:0] addr,
    input logic [rss_pkg::ADDR_W-1:0] off
  );
    reg_is = (addr == off);
  endfunction

  // monitor enable under power mode
  function automatic logic mon_gate(
    input logic en,
    input logic awake
  );
    mon_gate = en & awake;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [rss_pkg::CTRL_W-1:0] ctrl_r;
  logic [2*rss_pkg::LVL_W-1:0] level_r;
  logic [31:0] wdt_timeout_r;
  logic [31:0] wdt_cnt_r;
  logic wdt_en_r;
  logic wdt_fire_r;
  logic sw_req_r;
  logic ready_r;
  logic [rss_pkg::ST_W-1:0] status_r;
  logic [rss_pkg::ST_W-1:0] status_set;
  logic [23:0] buzz_cnt_r;
  rss_pkg::rss_seq_type seq_r;
  logic [rss_pkg::CNT_W-1:0] stretch_r;
  logic wr_acc;
  logic rd_setup;
  logic addr_ok;
  logic kick;
  logic awake;
  logic prec_hit;
  logic ext_low;
  logic alv_hit;
  logic dlv_hit;
  logic ahv_hit;
  logic alv_rst;
  logic dlv_rst;
  logic irq_event;
  logic rst_src;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  // decode, zero-wait answer
  assign addr_ok = reg_is(paddr, rss_pkg::OFF_CTRL)
                 | reg_is(paddr, rss_pkg::OFF_LEVEL)
                 | reg_is(paddr, rss_pkg::OFF_SWRST)
                 | reg_is(paddr, rss_pkg::OFF_WDT_CTRL)
                 | reg_is(paddr, rss_pkg::OFF_WDT_TIMEOUT)
                 | reg_is(paddr, rss_pkg::OFF_WDT_KICK)
                 | reg_is(paddr, rss_pkg::OFF_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_acc = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign kick = wr_acc & reg_is(paddr, rss_pkg::OFF_WDT_KICK);

  // read data captured in the setup cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        rss_pkg::OFF_CTRL: begin
          prdata[rss_pkg::CTRL_W-1:0] <= ctrl_r;
        end
        rss_pkg::OFF_LEVEL: begin
          prdata[2*rss_pkg::LVL_W-1:0] <= level_r;
        end
        rss_pkg::OFF_WDT_CTRL: begin
          prdata[rss_pkg::WDT_EN_BIT] <= wdt_en_r;
        end
        rss_pkg::OFF_WDT_TIMEOUT: begin
          prdata <= wdt_timeout_r;
        end
        rss_pkg::OFF_STATUS: begin
          prdata[rss_pkg::ST_W-1:0] <= status_r;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // cleared by any device reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= rss_pkg::CTRL_RST;
      level_r <= {rss_pkg::LVL_RST, rss_pkg::LVL_RST};
      wdt_timeout_r <= WDT_TIMEOUT_DEF;
    end else if (device_rst) begin
      ctrl_r <= rss_pkg::CTRL_RST;
      level_r <= {rss_pkg::LVL_RST, rss_pkg::LVL_RST};
      wdt_timeout_r <= WDT_TIMEOUT_DEF;
    end else if (wr_acc) begin
      if (reg_is(paddr, rss_pkg::OFF_CTRL)) begin
        ctrl_r <= pwdata[rss_pkg::CTRL_W-1:0];
      end
      if (reg_is(paddr, rss_pkg::OFF_LEVEL)) begin
        level_r <= pwdata[2*rss_pkg::LVL_W-1:0];
      end
      if (reg_is(paddr, rss_pkg::OFF_WDT_TIMEOUT)) begin
        wdt_timeout_r <= pwdata;
      end
    end
  end

  assign analog_low_level =
    level_r[rss_pkg::LVL_ALV_LSB +: rss_pkg::LVL_W];
  assign digital_low_level =
    level_r[rss_pkg::LVL_DLV_LSB +: rss_pkg::LVL_W];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_req_r <= 1'b0;
    end else begin
      sw_req_r <= wr_acc & reg_is(paddr, rss_pkg::OFF_SWRST)
                & pwdata[rss_pkg::SWRST_BIT]
                & ~ctrl_r[rss_pkg::CTRL_SW_DIS] & ~device_rst;
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // sticky enable, power-on clear only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_en_r <= 1'b0;
    end else if (wr_acc & reg_is(paddr, rss_pkg::OFF_WDT_CTRL)
                 & pwdata[rss_pkg::WDT_EN_BIT]) begin
      wdt_en_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_cnt_r <= 32'h0000_0000;
      wdt_fire_r <= 1'b0;
    end else if (~wdt_en_r | device_rst | kick) begin
      wdt_cnt_r <= 32'h0000_0000;
      wdt_fire_r <= 1'b0;
    end else if (wdt_cnt_r >= wdt_timeout_r) begin
      wdt_cnt_r <= 32'h0000_0000;
      wdt_fire_r <= 1'b1;
    end else begin
      wdt_cnt_r <= wdt_cnt_r + 32'h0000_0001;
      wdt_fire_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // power modes and monitor enables
  // ----------------------------------------
  // periodic buzz window in sleep
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      buzz_cnt_r <= 24'h00_0000;
      buzz <= 1'b0;
    end else if (~sleep_mode | hibernate_mode) begin
      buzz_cnt_r <= 24'h00_0000;
      buzz <= 1'b0;
    end else begin
      if (buzz_cnt_r == 24'(BUZZ_PERIOD - 1)) begin
        buzz_cnt_r <= 24'h00_0000;
      end else begin
        buzz_cnt_r <= buzz_cnt_r + 24'h00_0001;
      end
      buzz <= (buzz_cnt_r < 24'(BUZZ_LEN));
    end
  end

  assign awake = ~hibernate_mode & (~sleep_mode | buzz);

  // low and high monitors held off until power-on reset is over
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= 1'b1;
    end
  end

  // registered monitor enables
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mon_en <= '0;
    end else begin
      // digital precise monitor follows power mode only
      mon_en.prec_dig <= mon_gate(1'b1, awake);
      mon_en.prec_ana <= mon_gate(ctrl_r[rss_pkg::CTRL_AREG_EN], awake);
      // off during device reset, so a reset trip leaves no late irq
      mon_en.alv <= mon_gate(ctrl_r[rss_pkg::CTRL_ALV_EN] & ready_r & ~device_rst, awake);
      mon_en.dlv <= mon_gate(ctrl_r[rss_pkg::CTRL_DLV_EN] & ready_r & ~device_rst, awake);
      mon_en.ahv <= mon_gate(ctrl_r[rss_pkg::CTRL_AHV_EN] & ready_r & ~device_rst, awake);
    end
  end

  // trips count only from enabled monitors
  assign prec_hit = (trip.prec_dig & mon_en.prec_dig)
                  | (trip.prec_ana & mon_en.prec_ana);
  assign alv_hit = trip.alv & mon_en.alv;
  assign dlv_hit = trip.dlv & mon_en.dlv;
  assign ahv_hit = trip.ahv & mon_en.ahv;
  assign alv_rst = alv_hit & ctrl_r[rss_pkg::CTRL_ALV_RST];
  assign dlv_rst = dlv_hit & ctrl_r[rss_pkg::CTRL_DLV_RST];
  assign irq_event = (alv_hit & ~ctrl_r[rss_pkg::CTRL_ALV_RST])
                   | (dlv_hit & ~ctrl_r[rss_pkg::CTRL_DLV_RST])
                   | ahv_hit;

  // pin or selected gpio, never gated by power mode
  assign ext_low = ~external_reset_pin_n | (gpio_reset_sel & ~gpio_reset_n);

  // ----------------------------------------
  // reset combining and release
  // ----------------------------------------
  // all sources share one path
  assign rst_src = prec_hit | ext_low | sw_req_r | wdt_fire_r
                 | alv_rst | dlv_rst;

  // asserted at once, released from state
  assign device_rst = rst_src | (seq_r != rss_pkg::SEQ_RUN);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_r <= rss_pkg::SEQ_HOLD;
      stretch_r <= rss_pkg::STRETCH_LOAD;
    end else begin
      case (seq_r)
        rss_pkg::SEQ_HOLD: begin
          stretch_r <= rss_pkg::STRETCH_LOAD;
          if (~rst_src) begin
            seq_r <= rss_pkg::SEQ_STRETCH;
          end
        end
        rss_pkg::SEQ_STRETCH: begin
          if (rst_src) begin
            seq_r <= rss_pkg::SEQ_HOLD;
            stretch_r <= rss_pkg::STRETCH_LOAD;
          end else if (stretch_r == rss_pkg::CNT_ZERO) begin
            seq_r <= rss_pkg::SEQ_RUN;
          end else begin
            stretch_r <= stretch_r - 8'h01;
          end
        end
        rss_pkg::SEQ_RUN: begin
          if (rst_src) begin
            seq_r <= rss_pkg::SEQ_HOLD;
          end
        end
        default: begin
          seq_r <= rss_pkg::SEQ_HOLD;
          stretch_r <= rss_pkg::STRETCH_LOAD;
        end
      endcase
    end
  end

  // ----------------------------------------
  // status and interrupt
  // ----------------------------------------
  always_comb begin
    status_set = rss_pkg::ST_RST;
    status_set[rss_pkg::ST_PREC] = prec_hit;
    status_set[rss_pkg::ST_EXT] = ext_low;
    status_set[rss_pkg::ST_SW] = sw_req_r;
    status_set[rss_pkg::ST_WDT] = wdt_fire_r;
    status_set[rss_pkg::ST_ALV_RST] = alv_rst;
    status_set[rss_pkg::ST_DLV_RST] = dlv_rst;
    status_set[rss_pkg::ST_ALV_IRQ] = alv_hit & ~alv_rst;
    status_set[rss_pkg::ST_DLV_IRQ] = dlv_hit & ~dlv_rst;
    status_set[rss_pkg::ST_AHV_IRQ] = ahv_hit;
  end

  // sticky sources, write one to clear, set wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= rss_pkg::ST_RST;
    end else if (wr_acc & reg_is(paddr, rss_pkg::OFF_STATUS)) begin
      status_r <= (status_r & ~pwdata[rss_pkg::ST_W-1:0]) | status_set;
    end else begin
      status_r <= status_r | status_set;
    end
  end

  // wake first, interrupt only once awake
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeup_req <= 1'b0;
      supervisor_irq <= 1'b0;
    end else begin
      wakeup_req <= irq_event & sleep_mode;
      supervisor_irq <= (|status_r[rss_pkg::ST_AHV_IRQ:rss_pkg::ST_ALV_IRQ])
                      & ~sleep_mode & ~hibernate_mode;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_PREC_RESET: assert property (
    prec_hit |-> device_rst ##1 (seq_r == rss_pkg::SEQ_HOLD))
    else $error("precise trip did not reset");

  AST_ANA_FOLLOWS_REG: assert property (
    ~ctrl_r[rss_pkg::CTRL_AREG_EN] |=> ~mon_en.prec_ana)
    else $error("analog precise monitor on with regulator off");

  AST_HIB_OFF: assert property (
    hibernate_mode ##1 hibernate_mode |-> (mon_en == '0))
    else $error("monitor enabled in hibernate");

  AST_LV_WAIT_READY: assert property (
    ~ready_r |-> ~mon_en.alv & ~mon_en.dlv & ~mon_en.ahv)
    else $error("monitor enabled before power-on release");

  AST_SLEEP_WAKE: assert property (
    irq_event & sleep_mode |=> wakeup_req & ~supervisor_irq)
    else $error("sleep trip did not wake first");

  AST_EXT_HOLD: assert property (
    ext_low [*3] |-> device_rst & (seq_r == rss_pkg::SEQ_HOLD))
    else $error("external reset not held");

  AST_SW_RESET: assert property (
    wr_acc & reg_is(paddr, rss_pkg::OFF_SWRST) & pwdata[rss_pkg::SWRST_BIT]
    & ~ctrl_r[rss_pkg::CTRL_SW_DIS] & ~device_rst
    |=> sw_req_r & device_rst ##1 status_r[rss_pkg::ST_SW])
    else $error("software reset not taken");

  AST_SW_BLOCKED: assert property (
    ctrl_r[rss_pkg::CTRL_SW_DIS] |=> ~sw_req_r)
    else $error("software reset acted while disabled");

  AST_WDT_TIMEOUT: assert property (
    wdt_en_r & ~device_rst & ~kick & (wdt_cnt_r >= wdt_timeout_r)
    |=> wdt_fire_r ##1 device_rst)
    else $error("watchdog timeout missed");

  AST_WDT_STICKY: assert property (
    wdt_en_r |=> wdt_en_r)
    else $error("watchdog enable cleared");

  AST_MIN_WIDTH: assert property (
    $fell(device_rst) |-> $past(device_rst, 13))
    else $error("device reset shorter than minimum");

endmodule

`default_nettype wire

// ==== rss_mon_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module rss_mon_model (
  input wire logic clk,
  input wire logic [15:0] analog_mv,
  input wire logic [15:0] digital_mv,
  input wire logic prec_bad,
  input wire logic pin_low,
  input wire rss_pkg::rss_mon_type mon_en,
  input wire logic [rss_pkg::LVL_W-1:0] analog_low_level,
  input wire logic [rss_pkg::LVL_W-1:0] digital_low_level,
  output rss_pkg::rss_mon_type trip,
  output logic external_reset_pin_n
);
  // ----------------------------------------
  // comparators, a disabled one reads low
  // ----------------------------------------
  // sixteen step levels
  always_ff @(posedge clk) begin
    trip.prec_dig <= prec_bad & mon_en.prec_dig;
    trip.prec_ana <= prec_bad & mon_en.prec_ana;
    trip.alv <= mon_en.alv && (32'(analog_mv) <
      rss_pkg::LV_MIN_MV + 32'(analog_low_level) * rss_pkg::LV_STEP_MV);
    trip.dlv <= mon_en.dlv && (32'(digital_mv) <
      rss_pkg::LV_MIN_MV + 32'(digital_low_level) * rss_pkg::LV_STEP_MV);
    trip.ahv <= mon_en.ahv && (32'(analog_mv) > rss_pkg::AHV_TRIP_MV);
  end

  assign external_reset_pin_n = !pin_low;
endmodule

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, buzz, device_rst;
  logic supervisor_irq, wakeup_req, sleep_mode, hibernate_mode, gpio_reset_n, gpio_reset_sel;
  logic prec_bad, pin_low, external_reset_pin_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd_s;
  logic [3:0] analog_low_level, digital_low_level;
  logic [15:0] analog_mv, digital_mv;
  logic [7:0] lv;
  rss_pkg::rss_mon_type trip, mon_en;
  logic [32:0] exp_q[$];
  int fail_count = 0;
  int tests_run = 0;
  int n;

  rss_supervisor #(.WDT_TIMEOUT_DEF(32'h0000_0014), .BUZZ_PERIOD(20), .BUZZ_LEN(4)) dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trip(trip), .external_reset_pin_n(external_reset_pin_n), .gpio_reset_n(gpio_reset_n),
    .gpio_reset_sel(gpio_reset_sel), .sleep_mode(sleep_mode), .hibernate_mode(hibernate_mode),
    .mon_en(mon_en), .analog_low_level(analog_low_level), .digital_low_level(digital_low_level),
    .buzz(buzz), .device_rst(device_rst), .supervisor_irq(supervisor_irq), .wakeup_req(wakeup_req));

  rss_mon_model mon (
    .clk(clk), .analog_mv(analog_mv), .digital_mv(digital_mv), .prec_bad(prec_bad),
    .pin_low(pin_low), .mon_en(mon_en), .analog_low_level(analog_low_level),
    .digital_low_level(digital_low_level), .trip(trip), .external_reset_pin_n(external_reset_pin_n));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one apb transfer, reads leave their expectation
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk);
    if (!w) exp_q.push_back({a > rss_pkg::OFF_STATUS, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  // bounded wait for device reset level
  task automatic wait_rst(input logic lvl, output int c);
    c = 0;
    @(negedge clk);
    while (device_rst !== lvl && c < 300) begin
      @(negedge clk);
      c++;
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // read results taken off the queue at the access edge
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) chk({pslverr, prdata}, 33'h1_FFFF_FFFF);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ----------------------------------------
  // clock, watchdog, scenarios
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, sleep_mode, hibernate_mode, prec_bad, pin_low, gpio_reset_sel} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    gpio_reset_n = 1'b1;
    analog_mv = 16'h157C;
    digital_mv = 16'h157C;
    rnd_s = 32'h0000_BA98;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    wait_rst(1'b0, n);
    chk(n >= 14, 1'b1);
    rd(rss_pkg::OFF_CTRL, 32'h20);
    rd(rss_pkg::OFF_STATUS, 32'h0);
    rd(rss_pkg::OFF_WDT_CTRL, 32'h0);
    rd(12'h01C, 32'h0);
    wr(rss_pkg::OFF_CTRL, 32'h0);
    cyc(3);
    chk(mon_en.prec_dig, 1'b1);
    chk(mon_en.prec_ana, 1'b0);
    rnd_s = xs(rnd_s);
    lv = rnd_s[7:0];
    wr(rss_pkg::OFF_LEVEL, {24'h0, lv});
    rd(rss_pkg::OFF_LEVEL, {24'h0, lv});
    wr(rss_pkg::OFF_CTRL, 32'h27);
    cyc(3);
    chk({digital_low_level, analog_low_level}, lv);
    chk({mon_en.prec_ana, mon_en.alv, mon_en.dlv, mon_en.ahv}, 4'hF);
    @(posedge clk);
    analog_mv <= 16'(rss_pkg::LV_MIN_MV + 32'(lv[3:0]) * rss_pkg::LV_STEP_MV - 10);
    cyc(4);
    chk(supervisor_irq, 1'b1);
    rd(rss_pkg::OFF_STATUS, 32'h040);
    analog_mv <= 16'h16A8;
    cyc(3);
    rd(rss_pkg::OFF_STATUS, 32'h140);
    analog_mv <= 16'h157C;
    wr(rss_pkg::OFF_STATUS, 32'h1FF);
    rd(rss_pkg::OFF_STATUS, 32'h0);
    cyc(0);
    chk(device_rst, 1'b0);
    wr(rss_pkg::OFF_CTRL, 32'h3B);
    analog_mv <= 16'h0640;
    digital_mv <= 16'h0640;
    wait_rst(1'b1, n);
    chk(n < 5, 1'b1);
    @(posedge clk);
    analog_mv <= 16'h157C;
    digital_mv <= 16'h157C;
    wait_rst(1'b0, n);
    rd(rss_pkg::OFF_STATUS, 32'h030);
    rd(rss_pkg::OFF_CTRL, 32'h20);
    wr(rss_pkg::OFF_STATUS, 32'h1FF);
    prec_bad <= 1'b1;
    wait_rst(1'b1, n);
    chk(n < 3, 1'b1);
    @(posedge clk);
    prec_bad <= 1'b0;
    wait_rst(1'b0, n);
    chk(n >= 14, 1'b1);
    rd(rss_pkg::OFF_STATUS, 32'h001);
    wr(rss_pkg::OFF_STATUS, 32'h1FF);
    pin_low <= 1'b1;
    cyc(30);
    chk(device_rst, 1'b1);
    @(posedge clk);
    pin_low <= 1'b0;
    wait_rst(1'b0, n);
    chk(n >= 14, 1'b1);
    rd(rss_pkg::OFF_STATUS, 32'h002);
    gpio_reset_n <= 1'b0;
    cyc(5);
    chk(device_rst, 1'b0);
    @(posedge clk);
    gpio_reset_sel <= 1'b1;
    cyc(3);
    chk(device_rst, 1'b1);
    @(posedge clk);
    gpio_reset_n <= 1'b1;
    gpio_reset_sel <= 1'b0;
    wait_rst(1'b0, n);
    wr(rss_pkg::OFF_STATUS, 32'h1FF);
    wr(rss_pkg::OFF_SWRST, 32'h1);
    wait_rst(1'b1, n);
    chk(n < 3, 1'b1);
    wait_rst(1'b0, n);
    rd(rss_pkg::OFF_STATUS, 32'h004);
    wr(rss_pkg::OFF_STATUS, 32'h1FF);
    wr(rss_pkg::OFF_CTRL, 32'h60);
    wr(rss_pkg::OFF_SWRST, 32'h1);
    cyc(5);
    chk(device_rst, 1'b0);
    rd(rss_pkg::OFF_SWRST, 32'h0);
    wr(rss_pkg::OFF_CTRL, 32'h21);
    sleep_mode <= 1'b1;
    wait_rst(1'b1, n);
    chk(n >= 300, 1'b1);
    for (n = 0; buzz !== 1'b1 && n < 60; n++) @(negedge clk);
    cyc(1);
    chk(mon_en.prec_dig, 1'b1);
    for (n = 0; buzz !== 1'b0 && n < 60; n++) @(negedge clk);
    cyc(2);
    chk(mon_en.prec_dig, 1'b0);
    @(posedge clk);
    analog_mv <= 16'h0640;
    for (n = 0; wakeup_req !== 1'b1 && n < 60; n++) @(negedge clk);
    chk(wakeup_req, 1'b1);
    cyc(2);
    chk(supervisor_irq, 1'b0);
    @(posedge clk);
    sleep_mode <= 1'b0;
    analog_mv <= 16'h157C;
    cyc(3);
    chk(supervisor_irq, 1'b1);
    wr(rss_pkg::OFF_STATUS, 32'h1FF);
    hibernate_mode <= 1'b1;
    cyc(25);
    chk({buzz, mon_en.prec_dig}, 2'b00);
    @(posedge clk);
    pin_low <= 1'b1;
    cyc(3);
    chk(device_rst, 1'b1);
    @(posedge clk);
    pin_low <= 1'b0;
    hibernate_mode <= 1'b0;
    wait_rst(1'b0, n);
    wr(rss_pkg::OFF_STATUS, 32'h1FF);
    wr(rss_pkg::OFF_WDT_CTRL, 32'h1);
    wr(rss_pkg::OFF_WDT_CTRL, 32'h0);
    rd(rss_pkg::OFF_WDT_CTRL, 32'h1);
    repeat (3) begin
      rnd_s = xs(rnd_s);
      wr(rss_pkg::OFF_WDT_KICK, rnd_s);
      cyc(12);
    end
    chk(device_rst, 1'b0);
    wait_rst(1'b1, n);
    chk(n < 20, 1'b1);
    wait_rst(1'b0, n);
    rd(rss_pkg::OFF_STATUS, 32'h008);
    sys_rst <= 1'b1;
    cyc(2);
    @(posedge clk);
    sys_rst <= 1'b0;
    wait_rst(1'b0, n);
    rd(rss_pkg::OFF_WDT_CTRL, 32'h0);
    rd(rss_pkg::OFF_STATUS, 32'h0);
    cyc(40);
    chk(device_rst, 1'b0);
    stop_test();
  end
endmodule

`default_nettype wire
